// *** include/sacpc_pkg.sv ***
// Shared constants and types for the converter clock and power control block
package sacpc_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [15:0] SYS_CFG_IDX = 16'h1039;
  localparam logic [15:0] CONV_CTL_IDX = 16'h1030;
  localparam logic [15:0] RESULT_IDX = 16'h1031;
  localparam logic [15:0] SYS_CFG_ADDR = 16'h40e4;
  localparam logic [15:0] CONV_CTL_ADDR = 16'h40c0;
  localparam logic [15:0] RESULT_ADDR = 16'h40c4;
  localparam int ADDR_W = 16;
  // ==========================================================
  // Fields and reset values
  localparam int ANALOG_POWER_UP_BIT = 7;
  localparam int CONV_CLOCK_SELECT_BIT = 6;
  localparam int DONE_FLAG_BIT = 7;
  localparam logic [7:0] SYS_CFG_RESET = 8'h10;
  localparam logic [5:0] CONV_CTL_RESET = 6'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Timing counts in conversion clock ticks and bus cycles
  localparam logic [2:0] SAMPLE_TICKS = 3'h4;
  localparam logic [2:0] SYNC_CYCLES = 3'h2;
  localparam logic [2:0] MSB_IDX = 3'h7;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_SAMPLE = 3'b001,
    SEQ_CONV = 3'b010,
    SEQ_SYNC = 3'b011,
    SEQ_WRITE = 3'b100
  } sacpc_seq_state_t;
  typedef enum logic [1:0] {
    REG_NONE = 2'b00,
    REG_SYS_CFG = 2'b01,
    REG_CONV_CTL = 2'b10,
    REG_RESULT = 2'b11
  } sacpc_reg_sel_t;
  typedef struct packed {
    logic pump_en;
    logic pump_clk_rc;
    logic nvm_pump_clk_rc;
    logic offset_cap_high;
    logic comp_short;
    logic [7:0] cap_trial;
  } sacpc_analog_ctl_t;
endpackage

// *** rtl/sacpc_sar_seq.sv ***
// Successive-approximation sequencer with sample, sync and result write phases
`timescale 1ns/10ps
module sacpc_sar_seq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic start,
  input wire logic rc_mode,
  input wire logic conv_tick,
  input wire logic comp_out,
  input wire logic read_busy,
  output sacpc_pkg::sacpc_seq_state_t state,
  output logic [7:0] cap_trial,
  output logic [7:0] result,
  output logic done
);
  typedef struct packed {
    sacpc_pkg::sacpc_seq_state_t st;
    logic [2:0] cnt;
    logic [2:0] bit_idx;
    logic [7:0] sar;
    logic [7:0] result;
    logic done;
  } sacpc_seq_q_t;

  sacpc_seq_q_t q;
  sacpc_seq_q_t d;
  logic [7:0] trial;

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.done = 1'b0;
    trial = q.sar;
    if (start) begin
      d.st = sacpc_pkg::SEQ_SAMPLE;
      d.cnt = 3'h0;
      d.sar = 8'h00;
    end else begin
      case (q.st)
        sacpc_pkg::SEQ_SAMPLE: begin
          if (conv_tick) begin
            if (q.cnt == sacpc_pkg::SAMPLE_TICKS - 3'h1) begin
              d.st = sacpc_pkg::SEQ_CONV;
              d.bit_idx = sacpc_pkg::MSB_IDX;
              d.sar = 8'h80;
            end else begin
              d.cnt = q.cnt + 3'h1;
            end
          end
        end
        sacpc_pkg::SEQ_CONV: begin
          if (conv_tick) begin
            if (!comp_out) begin
              trial[q.bit_idx] = 1'b0;
            end
            if (q.bit_idx != 3'h0) begin
              trial[q.bit_idx - 3'h1] = 1'b1;
              d.bit_idx = q.bit_idx - 3'h1;
            end else if (rc_mode) begin
              d.st = sacpc_pkg::SEQ_SYNC;
              d.cnt = 3'h0;
            end else begin
              d.st = sacpc_pkg::SEQ_WRITE;
            end
            d.sar = trial;
          end
        end
        sacpc_pkg::SEQ_SYNC: begin
          if (q.cnt == sacpc_pkg::SYNC_CYCLES - 3'h1) begin
            d.st = sacpc_pkg::SEQ_WRITE;
          end else begin
            d.cnt = q.cnt + 3'h1;
          end
        end
        sacpc_pkg::SEQ_WRITE: begin
          if (!read_busy) begin
            d.result = q.sar;
            d.done = 1'b1;
            d.st = sacpc_pkg::SEQ_IDLE;
          end
        end
        default: begin
          d.st = sacpc_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '{st: sacpc_pkg::SEQ_IDLE, cnt: 3'h0, bit_idx: 3'h0, sar: 8'h00,
             result: 8'h00, done: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end

  assign state = q.st;
  assign cap_trial = (q.st == sacpc_pkg::SEQ_CONV) ? q.sar : 8'h00;
  assign result = q.result;
  assign done = q.done;

  // ==========================================================
  // Checks
  chk_msb_first_trial: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (q.st == sacpc_pkg::SEQ_SAMPLE && d.st == sacpc_pkg::SEQ_CONV && !start)
    |=> (q.bit_idx == 3'h7 && q.sar == 8'h80))
    else $error("Conversion did not open with the top bit trial");
  chk_bit_cleared: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (q.st == sacpc_pkg::SEQ_CONV && conv_tick && !comp_out && !start)
    |=> (q.sar[$past(q.bit_idx)] == 1'b0))
    else $error("Rejected trial bit was kept");
  chk_bit_kept: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (q.st == sacpc_pkg::SEQ_CONV && conv_tick && comp_out && !start)
    |=> (q.sar[$past(q.bit_idx)] == 1'b1))
    else $error("Accepted trial bit was dropped");
  chk_lsb_final_step: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (q.st == sacpc_pkg::SEQ_CONV && conv_tick && q.bit_idx == 3'h0 && !start)
    |=> (q.st != sacpc_pkg::SEQ_CONV && cap_trial == 8'h00))
    else $error("Conversion continued past the last bit");
  chk_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (q.st == sacpc_pkg::SEQ_CONV && d.st == sacpc_pkg::SEQ_SYNC && !start)
    |=> (!done && q.st == sacpc_pkg::SEQ_SYNC) [*2])
    else $error("Result written without the sync delay");
  chk_no_write_on_read: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (q.st == sacpc_pkg::SEQ_WRITE && read_busy && !start) |=> (!done && $stable(result)))
    else $error("Result updated during a read");
  chk_start_aborts: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    start |=> (q.st == sacpc_pkg::SEQ_SAMPLE && q.cnt == 3'h0 && !done))
    else $error("Start did not restart the sequence");
endmodule

// *** rtl/sacpc_top.sv ***
// Converter clock and power control with an AXI4-Lite register slave
//
// Contract
// - The sequencer resolves from the top bit, trial-setting each bit and keeping it on a one.
// - On the last step the lowest bit clears on a zero and the conversion simply ends.
// - The half-unit offset capacitor sits on the high reference only while sampling.
// - Comparator inputs and output are shorted while sampling and released before trials.
// - The converter charge pump is off after reset and runs only while power-up is set.
// - Clock select one picks the RC oscillator for sequencer and pump, else the bus clock.
// - The same select switches the nonvolatile-memory charge pump clock as well.
// - On the bus clock the comparator is sampled at quiet points and results avoid reads.
// - On the RC clock a sync delay ends each conversion before the result moves over.
// - Configuration holds power-up in bit 7 and clock select in bit 6, both zero at reset.
// - Each write to the control register with strobe bit 0 set clears the done flag and restarts a conversion; a seq_done in that cycle keeps the flag set.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module sacpc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rc_osc_tick,
  input wire logic comp_out,
  output sacpc_pkg::sacpc_analog_ctl_t analog_ctl,
  output logic conv_busy
);
  typedef struct packed {
    logic aw_full;
    logic [15:0] aw_addr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] sys_cfg;
    logic [5:0] conv_ctl;
    logic done_flag;
  } sacpc_top_q_t;

  sacpc_top_q_t q;
  sacpc_top_q_t d;
  sacpc_pkg::sacpc_seq_state_t seq_state;
  logic [7:0] cap_trial;
  logic [7:0] result;
  logic seq_done;
  logic start;
  logic read_fire;
  logic write_fire;
  logic rc_mode;
  logic conv_tick;
  sacpc_pkg::sacpc_reg_sel_t wr_sel;
  sacpc_pkg::sacpc_reg_sel_t rd_sel;

  // ==========================================================
  // Address decode
  function automatic sacpc_pkg::sacpc_reg_sel_t reg_decode(input logic [15:0] addr);
    case (addr)
      sacpc_pkg::SYS_CFG_ADDR: reg_decode = sacpc_pkg::REG_SYS_CFG;
      sacpc_pkg::CONV_CTL_ADDR: reg_decode = sacpc_pkg::REG_CONV_CTL;
      sacpc_pkg::RESULT_ADDR: reg_decode = sacpc_pkg::REG_RESULT;
      default: reg_decode = sacpc_pkg::REG_NONE;
    endcase
  endfunction

  assign wr_sel = reg_decode(q.aw_addr);
  assign rd_sel = reg_decode(s_axi_araddr);
  assign s_axi_awready = !q.aw_full && !q.bvalid;
  assign s_axi_wready = !q.w_full && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign read_fire = s_axi_arvalid && s_axi_arready;
  assign write_fire = q.aw_full && q.w_full && !q.bvalid;
  assign start = write_fire && wr_sel == sacpc_pkg::REG_CONV_CTL && q.wstrb[0];

  // ==========================================================
  // Conversion clock selection
  assign rc_mode = q.sys_cfg[sacpc_pkg::CONV_CLOCK_SELECT_BIT];
  assign conv_tick = rc_mode ? rc_osc_tick : 1'b1;

  sacpc_sar_seq u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(start),
    .rc_mode(rc_mode),
    .conv_tick(conv_tick),
    .comp_out(comp_out),
    .read_busy(read_fire),
    .state(seq_state),
    .cap_trial(cap_trial),
    .result(result),
    .done(seq_done)
  );

  // ==========================================================
  // Register bus and registers
  always_comb begin
    d = q;
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_full = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_full = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (write_fire) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = sacpc_pkg::RESP_OKAY;
      case (wr_sel)
        sacpc_pkg::REG_SYS_CFG: begin
          if (q.wstrb[0]) begin
            d.sys_cfg = q.wdata[7:0];
          end
        end
        sacpc_pkg::REG_CONV_CTL: begin
          if (q.wstrb[0]) begin
            d.conv_ctl = q.wdata[5:0];
            d.done_flag = 1'b0;
          end
        end
        sacpc_pkg::REG_RESULT: begin
          d.bresp = sacpc_pkg::RESP_OKAY;
        end
        default: begin
          d.bresp = sacpc_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (seq_done) begin
      d.done_flag = 1'b1;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (read_fire) begin
      d.rvalid = 1'b1;
      d.rresp = sacpc_pkg::RESP_OKAY;
      case (rd_sel)
        sacpc_pkg::REG_SYS_CFG: d.rdata = {24'h000000, q.sys_cfg};
        sacpc_pkg::REG_CONV_CTL: d.rdata = {24'h000000, q.done_flag, 1'b0, q.conv_ctl};
        sacpc_pkg::REG_RESULT: d.rdata = {24'h000000, result};
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = sacpc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '{aw_full: 1'b0, aw_addr: 16'h0000, w_full: 1'b0, wdata: 32'h00000000,
             wstrb: 4'h0, bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0, rdata: 32'h00000000,
             rresp: 2'h0, sys_cfg: sacpc_pkg::SYS_CFG_RESET,
             conv_ctl: sacpc_pkg::CONV_CTL_RESET, done_flag: 1'b0};
    end else if (ce) begin
      q <= d;
    end
  end

  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // ==========================================================
  // Analog switch and pump controls
  assign analog_ctl.pump_en = q.sys_cfg[sacpc_pkg::ANALOG_POWER_UP_BIT];
  assign analog_ctl.pump_clk_rc = rc_mode;
  assign analog_ctl.nvm_pump_clk_rc = rc_mode;
  assign analog_ctl.offset_cap_high = seq_state == sacpc_pkg::SEQ_SAMPLE;
  assign analog_ctl.comp_short = seq_state == sacpc_pkg::SEQ_SAMPLE;
  assign analog_ctl.cap_trial = cap_trial;
  assign conv_busy = seq_state != sacpc_pkg::SEQ_IDLE;

  // ==========================================================
  // Checks
  chk_pump_follows_cfg: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (write_fire && wr_sel == sacpc_pkg::REG_SYS_CFG && q.wstrb[0])
    |=> (analog_ctl.pump_en == $past(q.wdata[7])))
    else $error("Pump enable did not follow the power-up bit");
  chk_pump_off_reset: assert property (@(posedge aclk)
    !aresetn |=> (!analog_ctl.pump_en && !analog_ctl.pump_clk_rc))
    else $error("Pump or clock select not cleared by reset");
  chk_clock_sel_pair: assert property (@(posedge aclk) disable iff (!aresetn)
    analog_ctl.nvm_pump_clk_rc == analog_ctl.pump_clk_rc
    && analog_ctl.nvm_pump_clk_rc == q.sys_cfg[sacpc_pkg::CONV_CLOCK_SELECT_BIT])
    else $error("Pump clock selects disagree");
  chk_offset_cap_phase: assert property (@(posedge aclk) disable iff (!aresetn)
    (analog_ctl.offset_cap_high && analog_ctl.comp_short) || (!analog_ctl.offset_cap_high
    && !analog_ctl.comp_short) ##0 (analog_ctl.cap_trial == 8'h00 || !analog_ctl.comp_short))
    else $error("Offset capacitor or short out of the sample phase");
  chk_short_released: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (seq_state == sacpc_pkg::SEQ_CONV) |-> (!analog_ctl.comp_short && !analog_ctl.offset_cap_high))
    else $error("Short still applied during trials");
  chk_done_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    (start && !seq_done) |=> (!q.done_flag && seq_state == sacpc_pkg::SEQ_SAMPLE))
    else $error("Control write did not clear the done flag");
  chk_done_flag_set: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
    seq_done |=> q.done_flag)
    else $error("Done flag not set at the end of a conversion");
endmodule

// *** verif/sacpc_adc_model.sv ***
// Behavioural comparator and RC oscillator on the far side of the converter control
`timescale 1ns/10ps
module sacpc_adc_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire sacpc_pkg::sacpc_analog_ctl_t analog_ctl,
  input wire logic [7:0] level,
  input wire logic [1:0] rc_div,
  output logic comp_out,
  output logic rc_osc_tick
);
  logic [1:0] cnt_q;
  logic junk_q;
  // ==========
  // Free running oscillator, one tick every rc_div+1 bus cycles
  always_ff @(posedge aclk) begin
    cnt_q <= (!aresetn || cnt_q >= rc_div) ? 2'h0 : cnt_q + 2'h1;
    junk_q <= aresetn ? !junk_q : 1'b0;
  end
  assign rc_osc_tick = (cnt_q == rc_div);
  // ==========
  // Comparator says keep while the trial code is not above the input
  // Outside trials the shorted comparator has no stable level
  assign comp_out = (analog_ctl.cap_trial != 8'h00) ? (analog_ctl.cap_trial <= level) : junk_q;
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the converter clock and power control
`timescale 1ns/10ps
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [7:0] level = 8'h0;
  logic [1:0] rc_div = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, comp_out, rc_osc_tick, conv_busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  sacpc_pkg::sacpc_analog_ctl_t analog_ctl;
  int num_errors = 0;
  int checks = 0;
  int seed = 33469;
  int dur0, dur1;
  logic [31:0] v;
  always #5 aclk = ~aclk;
  sacpc_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rc_osc_tick(rc_osc_tick), .comp_out(comp_out), .analog_ctl(analog_ctl),
    .conv_busy(conv_busy));
  sacpc_adc_model far_u (.aclk(aclk), .aresetn(aresetn), .analog_ctl(analog_ctl),
    .level(level), .rc_div(rc_div), .comp_out(comp_out), .rc_osc_tick(rc_osc_tick));
  // ==========
  // Checking and closing
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({31'h0, got}, {31'h0, exp});
  endtask
  task automatic timeout();
    num_errors++;
    report_and_stop();
  endtask
  function automatic logic [7:0] sar_exp(input logic [7:0] lv);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      r[i] = 1'b1;
      if (r > lv) r[i] = 1'b0;
    end
    return r;
  endfunction
  // ==========
  // Register bus master
  task automatic wr_chk(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    int n;
    logic ta, tw, tr;
    logic [1:0] r;
    n = 0;
    tr = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = bready && bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
      if (n > 200) timeout();
    end
    cmp_val({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rready && rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      n++;
      if (n > 200) timeout();
    end
    cmp_val(d, ed);
    cmp_val({30'h0, r}, {30'h0, er});
  endtask
  // ==========
  // Configuration and conversion sequences
  task automatic cfg_set(input logic [7:0] c);
    wr_chk(sacpc_pkg::SYS_CFG_ADDR, {24'h0, c}, 4'hf, sacpc_pkg::RESP_OKAY);
    @(negedge aclk);
    cmp_bit(analog_ctl.pump_en, c[7]);
    cmp_bit(analog_ctl.pump_clk_rc, c[6]);
    cmp_bit(analog_ctl.nvm_pump_clk_rc, c[6]);
    @(posedge aclk);
    rd_chk(sacpc_pkg::SYS_CFG_ADDR, {24'h0, c}, sacpc_pkg::RESP_OKAY);
  endtask
  task automatic convert(input logic [7:0] lv, output int dur);
    level <= lv;
    wr_chk(sacpc_pkg::CONV_CTL_ADDR, 32'h0, 4'hf, sacpc_pkg::RESP_OKAY);
    @(negedge aclk);
    cmp_bit(conv_busy, 1'b1);
    cmp_bit(analog_ctl.comp_short, 1'b1);
    cmp_bit(analog_ctl.offset_cap_high, 1'b1);
    @(posedge aclk);
    rd_chk(sacpc_pkg::CONV_CTL_ADDR, 32'h0, sacpc_pkg::RESP_OKAY);
    dur = 0;
    do begin
      @(negedge aclk);
      dur++;
      if (dur > 400) timeout();
    end while (conv_busy);
    @(posedge aclk);
    rd_chk(sacpc_pkg::RESULT_ADDR, {24'h0, sar_exp(lv)}, 2'h0);
    rd_chk(sacpc_pkg::CONV_CTL_ADDR, 32'h80, sacpc_pkg::RESP_OKAY);
  endtask
  // ==========
  // Switch phasing watched on every cycle
  always @(negedge aclk) begin
    if (aresetn && analog_ctl.cap_trial != 8'h00) begin
      cmp_bit(analog_ctl.comp_short, 1'b0);
      cmp_bit(analog_ctl.offset_cap_high, 1'b0);
    end
    if (aresetn) cmp_bit(analog_ctl.nvm_pump_clk_rc, analog_ctl.pump_clk_rc);
  end
  // ==========
  // Main sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    cmp_val({19'h0, analog_ctl}, 32'h0);
    @(posedge aclk);
    rd_chk(sacpc_pkg::SYS_CFG_ADDR, 32'h10, sacpc_pkg::RESP_OKAY);
    rd_chk(sacpc_pkg::CONV_CTL_ADDR, 32'h0, sacpc_pkg::RESP_OKAY);
    rd_chk(sacpc_pkg::RESULT_ADDR, 32'h0, sacpc_pkg::RESP_OKAY);
    rd_chk(16'h0100, 32'h0, sacpc_pkg::RESP_SLVERR);
    wr_chk(16'h0100, 32'h5, 4'hf, sacpc_pkg::RESP_SLVERR);
    wr_chk(sacpc_pkg::RESULT_ADDR, 32'h5a, 4'hf, sacpc_pkg::RESP_OKAY);
    rd_chk(sacpc_pkg::RESULT_ADDR, 32'h0, sacpc_pkg::RESP_OKAY);
    wr_chk(sacpc_pkg::SYS_CFG_ADDR, 32'hff, 4'h0, sacpc_pkg::RESP_OKAY);
    rd_chk(sacpc_pkg::SYS_CFG_ADDR, 32'h10, sacpc_pkg::RESP_OKAY);
    cfg_set(8'h80);
    repeat (50) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      convert(8'h01 << i, dur0);
    end
    convert(8'h00, dur0);
    convert(8'hff, dur0);
    rc_div <= 2'h0;
    cfg_set(8'hc0);
    repeat (20) @(posedge aclk);
    convert(8'hff, dur1);
    cmp_val(32'(dur1 - dur0), {29'h0, sacpc_pkg::SYNC_CYCLES});
    cfg_set(8'h80);
    repeat (20) @(posedge aclk);
    level <= 8'h3c;
    wr_chk(sacpc_pkg::CONV_CTL_ADDR, 32'h0, 4'hf, sacpc_pkg::RESP_OKAY);
    repeat (6) @(posedge aclk);
    convert(8'hc3, dur1);
    // Reads every other cycle so one of the two runs lands on the result write
    for (int k = 0; k < 2; k++) begin
      v = {24'h0, 8'h5a ^ k[7:0]};
      level <= v[7:0];
      wr_chk(sacpc_pkg::CONV_CTL_ADDR, 32'h0, 4'hf, sacpc_pkg::RESP_OKAY);
      repeat (k) @(posedge aclk);
      repeat (10) rd_chk(sacpc_pkg::SYS_CFG_ADDR, 32'h80, sacpc_pkg::RESP_OKAY);
      rd_chk(sacpc_pkg::RESULT_ADDR, {24'h0, sar_exp(v[7:0])}, sacpc_pkg::RESP_OKAY);
    end
    for (int k = 0; k < 8; k++) begin
      v = $random(seed);
      rc_div <= v[10:9];
      cfg_set({1'b1, v[8], v[21:16]});
      repeat (20) @(posedge aclk);
      convert(v[7:0], dur1);
    end
    cfg_set(8'h10);
    report_and_stop();
  end
endmodule
